// ===== reserved_field_pkg.sv
`default_nettype none

package reserved_field_pkg;

    // ****************************************
    // per-bit field kinds
    // ****************************************
    localparam int KW = 4;
    localparam logic [KW-1:0] KIND_NORMAL        = 4'h0;
    localparam logic [KW-1:0] KIND_ZERO_RWI      = 4'h1;
    localparam logic [KW-1:0] KIND_ONES_RWI      = 4'h2;
    localparam logic [KW-1:0] KIND_ZRSV_FIXED    = 4'h3;
    localparam logic [KW-1:0] KIND_ORSV_FIXED    = 4'h4;
    localparam logic [KW-1:0] KIND_ZRSV_STORED   = 4'h5;
    localparam logic [KW-1:0] KIND_ORSV_STORED   = 4'h6;
    localparam logic [KW-1:0] KIND_ZRSV_CTX      = 4'h7;
    localparam logic [KW-1:0] KIND_ORSV_CTX      = 4'h8;
    localparam logic [KW-1:0] KIND_WZERO_POLICY  = 4'h9;
    localparam logic [KW-1:0] KIND_WONE_POLICY   = 4'hA;
    localparam logic [KW-1:0] KIND_WZERO_PRESERV = 4'hB;
    localparam logic [KW-1:0] KIND_WONE_PRESERV  = 4'hC;

    // ****************************************
    // access sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_WRITE = 3'h2,
        ST_READ  = 3'h4
    } acc_state_e;

    // ****************************************
    // kind decoding shared by bank and cell
    // ****************************************
    // bit owns a flip-flop
    function automatic logic kindStored(input logic [KW-1:0] k);
        return (k == KIND_NORMAL) || (k == KIND_ZRSV_STORED) || (k == KIND_ORSV_STORED)
            || (k == KIND_ZRSV_CTX) || (k == KIND_ORSV_CTX);
    endfunction

    // reserved or constant value of the bit (one for the "ones" kinds)
    function automatic logic kindResVal(input logic [KW-1:0] k);
        return (k == KIND_ONES_RWI) || (k == KIND_ORSV_FIXED) || (k == KIND_ORSV_STORED)
            || (k == KIND_ORSV_CTX) || (k == KIND_WONE_POLICY) || (k == KIND_WONE_PRESERV);
    endfunction

    // software is expected to write only the reserved value here
    function automatic logic kindPolicy(input logic [KW-1:0] k);
        return (k == KIND_WZERO_POLICY) || (k == KIND_WONE_POLICY)
            || (k == KIND_WZERO_PRESERV) || (k == KIND_WONE_PRESERV)
            || (k == KIND_ZRSV_FIXED) || (k == KIND_ORSV_FIXED);
    endfunction

endpackage

`default_nettype wire

// ===== reserved_bit_cell.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// one register bit with its access policy
// ****************************************
module reserved_bit_cell #(
    parameter logic [reserved_field_pkg::KW-1:0] KIND    = reserved_field_pkg::KIND_NORMAL,
    parameter logic                              RST_BIT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic dirWr,
    input  wire logic indWr,
    input  wire logic dataBit,
    input  wire logic ctxRes,
    output var  logic readBit,
    output var  logic funcBit
);

    localparam logic RES_VAL = reserved_field_pkg::kindResVal(KIND);
    localparam logic IS_CTX  = (KIND == reserved_field_pkg::KIND_ZRSV_CTX)
                            || (KIND == reserved_field_pkg::KIND_ORSV_CTX);
    localparam logic IS_RES  = (KIND == reserved_field_pkg::KIND_ZRSV_STORED)
                            || (KIND == reserved_field_pkg::KIND_ORSV_STORED);
    // reserved storage starts at its reserved value, others at the reset value
    localparam logic INIT    = IS_RES ? RES_VAL : RST_BIT;

    generate
        if (reserved_field_pkg::kindStored(KIND)) begin : g_store
            logic bit_reg;
            logic bit_next;
            logic indVal;

            // indirect write loads the reserved value while the bit is reserved
            assign indVal   = (IS_RES || (IS_CTX && ctxRes)) ? RES_VAL : dataBit;
            assign bit_next = dirWr ? dataBit : (indWr ? indVal : bit_reg);

            // readback is the last value that landed, whatever the context was
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    bit_reg <= INIT;
                end else begin
                    bit_reg <= bit_next;
                end
            end

            assign readBit = bit_reg;
            // reserved storage never steers the device, only readback
            assign funcBit = (IS_RES || (IS_CTX && ctxRes)) ? RES_VAL : bit_reg;
        end else begin : g_const
            // hard-wired: writes have nowhere to land
            assign readBit = RES_VAL;
            assign funcBit = RES_VAL;
        end
    endgenerate

endmodule // reserved_bit_cell

`default_nettype wire

// ===== reserved_field_bank.sv
`timescale 1ns/1ps
`default_nettype none


module reserved_field_bank #(
    parameter int                                        WIDTH       = 32,
    // per-bit kind, bit n uses slice [n*KW +: KW]
    parameter logic [WIDTH*reserved_field_pkg::KW-1:0]   FIELD_KIND  = '0,
    parameter logic [WIDTH-1:0]                          RESET_VALUE = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             reqValid,
    input  wire logic             reqWrite,
    input  wire logic             reqDirect,
    input  wire logic [WIDTH-1:0] reqMask,
    input  wire logic [WIDTH-1:0] reqData,
    input  wire logic [WIDTH-1:0] ctxReserved,
    output var  logic             busy,
    output var  logic             ackValid,
    output var  logic [WIDTH-1:0] rdData,
    output var  logic [WIDTH-1:0] funcValue,
    output var  logic             ignoredWrite,
    output var  logic             policyBreach
);

    // ****************************************
    // access sequencer
    // ****************************************
    reserved_field_pkg::acc_state_e state_reg;
    reserved_field_pkg::acc_state_e state_next;

    logic             take;
    logic             direct_reg;
    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] data_reg;

    // a request is only taken while idle; busy tells the caller to hold
    assign take = reqValid && (state_reg == reserved_field_pkg::ST_IDLE);

    // one cycle to apply, then back to idle
    always_comb begin
        case (state_reg)
            reserved_field_pkg::ST_IDLE: begin
                if (take && reqWrite) begin
                    state_next = reserved_field_pkg::ST_WRITE;
                end else if (take) begin
                    state_next = reserved_field_pkg::ST_READ;
                end else begin
                    state_next = reserved_field_pkg::ST_IDLE;
                end
            end
            reserved_field_pkg::ST_WRITE: state_next = reserved_field_pkg::ST_IDLE;
            reserved_field_pkg::ST_READ:  state_next = reserved_field_pkg::ST_IDLE;
            default:                      state_next = reserved_field_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= reserved_field_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request fields captured at take so the caller may move on
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            direct_reg <= 1'b0;
            mask_reg   <= '0;
            data_reg   <= '0;
        end else if (take) begin
            direct_reg <= reqDirect;
            mask_reg   <= reqMask;
            data_reg   <= reqData;
        end
    end

    // ****************************************
    // bit cells
    // ****************************************
    logic             doWrite;
    logic             doRead;
    logic [WIDTH-1:0] dirWr;
    logic [WIDTH-1:0] readVec;
    logic [WIDTH-1:0] funcVec;
    logic [WIDTH-1:0] constBits;
    logic [WIDTH-1:0] policyBits;
    logic [WIDTH-1:0] resVec;

    assign doWrite = (state_reg == reserved_field_pkg::ST_WRITE);
    assign doRead  = (state_reg == reserved_field_pkg::ST_READ);

    // each bit gets the storage or wiring its kind asks for
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            localparam logic [reserved_field_pkg::KW-1:0] K =
                FIELD_KIND[gi*reserved_field_pkg::KW +: reserved_field_pkg::KW];

            // direct write reaches only bits named in the mask
            assign dirWr[gi]      = doWrite && direct_reg && mask_reg[gi];
            assign constBits[gi]  = !reserved_field_pkg::kindStored(K);
            assign policyBits[gi] = reserved_field_pkg::kindPolicy(K);
            assign resVec[gi]     = reserved_field_pkg::kindResVal(K);

            // the kind is fixed per bit at build time, never at run time
            reserved_bit_cell #(
                .KIND    (K),
                .RST_BIT (RESET_VALUE[gi])
            ) u_cell (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .dirWr   (dirWr[gi]),
                .indWr   (doWrite && !direct_reg),
                .dataBit (data_reg[gi]),
                .ctxRes  (ctxReserved[gi]),
                .readBit (readVec[gi]),
                .funcBit (funcVec[gi])
            );
        end
    endgenerate

    // ****************************************
    // write checking
    // ****************************************
    logic [WIDTH-1:0] touched;
    logic             hitsIgnored;
    logic             breachNow;

    // bits reached by this write, directly or through the whole register
    assign touched     = direct_reg ? mask_reg : {WIDTH{1'b1}};
    // writes aimed at hard-wired bits vanish; flag it for the caller
    // only a direct write can aim at a bit; whole-register writes stay quiet
    assign hitsIgnored = doWrite && direct_reg && |(mask_reg & constBits);
    // software owes the reserved value on policy bits; preserve equals it
    // here, since these bits only ever read their reserved value
    assign breachNow   = doWrite
                      && |(touched & policyBits & (data_reg ^ resVec));

    // ****************************************
    // registered outputs
    // ****************************************
    // ack one cycle after the sequencer leaves idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy     <= 1'b0;
            ackValid <= 1'b0;
        end else begin
            busy     <= take;
            ackValid <= doWrite || doRead;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else if (doRead) begin
            rdData <= readVec;
        end
    end

    // device-facing value, reserved positions forced to reserved value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            funcValue <= '0;
        end else begin
            funcValue <= funcVec;
        end
    end

    // one-cycle warnings that come with the write ack
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ignoredWrite <= 1'b0;
            policyBreach <= 1'b0;
        end else begin
            ignoredWrite <= hitsIgnored;
            policyBreach <= breachNow;
        end
    end

endmodule // reserved_field_bank

`default_nettype wire

// ===== reserved_field_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module reserved_field_monitor #(
    parameter int WIDTH = 32
) (
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic             reqValid,
    input wire logic             reqWrite,
    input wire logic             reqDirect,
    input wire logic [WIDTH-1:0] reqMask,
    input wire logic [WIDTH-1:0] reqData,
    input wire logic [WIDTH-1:0] ctxReserved,
    input wire logic             busy,
    input wire logic             ackValid,
    input wire logic [WIDTH-1:0] rdData,
    input wire logic [WIDTH-1:0] funcValue,
    input wire logic             ignoredWrite,
    input wire logic             policyBreach
);
    // ****************************************
    // access timing and flag checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a request counts only while the sequencer is idle
    wire logic take = reqValid && !busy;
    property p_ack_time; take |=> busy && !ackValid ##1 ackValid && !busy; endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack not two edges after take");
    property p_busy_once; busy |=> !busy; endproperty
    a_busy_once: assert property (p_busy_once) else $error("busy longer than one cycle");
    property p_ack_once; ackValid |=> !ackValid; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_flag_ack; ignoredWrite || policyBreach |-> ackValid; endproperty
    a_flag_ack: assert property (p_flag_ack) else $error("flag without ack");
    property p_rd_hold; !ackValid |-> $stable(rdData); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without ack");
    property p_wr_rd; take && reqWrite |-> ##2 $stable(rdData); endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("write changed read data");
    property p_ind_clean; take && reqWrite && !reqDirect |-> ##2 !ignoredWrite; endproperty
    a_ind_clean: assert property (p_ind_clean) else $error("indirect write flagged");
    property p_rd_clean; take && !reqWrite |-> ##2 !ignoredWrite && !policyBreach; endproperty
    a_rd_clean: assert property (p_rd_clean) else $error("read raised a flag");
    property p_no_mask;
        take && reqWrite && reqDirect && reqMask == '0 |-> ##2 !ignoredWrite && !policyBreach;
    endproperty
    a_no_mask: assert property (p_no_mask) else $error("empty mask raised a flag");
endmodule // reserved_field_monitor
`default_nettype wire

// ===== test_reserved_field_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_reserved_field_bank;
    // ****************************************
    // bit n has kind n, bits 13..15 normal
    // ****************************************
    localparam int             W     = 16;
    localparam logic [W*4-1:0] KINDS = 64'h000C_BA98_7654_3210;
    localparam logic [W-1:0]   RSTV  = 16'hA5A5;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic         reqValid = 1'b0;
    logic         reqWrite = 1'b0;
    logic         reqDirect = 1'b0;
    logic [W-1:0] reqMask = '0;
    logic [W-1:0] reqData = '0;
    logic [W-1:0] ctxReserved = '0;
    logic         busy, ackValid, ignoredWrite, policyBreach;
    logic [W-1:0] rdData, funcValue, model, stM, rvM, conM, polM, resM, ctxM;
    int           err_total = 0;
    int           checks_done = 0;
    int           kd;

    reserved_field_bank #(.WIDTH(W), .FIELD_KIND(KINDS), .RESET_VALUE(RSTV))
        reserved_field_bank_i (
        .clk_sys, .rst_n, .reqValid, .reqWrite, .reqDirect, .reqMask, .reqData,
        .ctxReserved, .busy, .ackValid, .rdData, .funcValue, .ignoredWrite, .policyBreach);

    initial forever #50 clk_sys = ~clk_sys;

    // ****************************************
    // compare, expectation and closing helpers
    // ****************************************
    task automatic check(input string nm, input logic [W-1:0] seen, input logic [W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // stored bits in g show the model, the rest their reserved value
    function automatic logic [W-1:0] view(input logic [W-1:0] g);
        return (model & g) | (rvM & ~g);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one request, inputs change at falling edges only
    task automatic op(input logic w, input logic d, input logic [W-1:0] m, dat, cx);
        logic [W-1:0] f;
        logic [W-1:0] t;
        f = resM | (ctxM & cx);
        t = d ? m : '1;
        @(negedge clk_sys);
        reqValid = 1'b1;
        reqWrite = w;
        reqDirect = d;
        reqMask = m;
        reqData = dat;
        ctxReserved = cx;
        @(negedge clk_sys);
        reqValid = 1'b0;
        check("busy", W'(busy), W'(1'b1));
        @(negedge clk_sys);
        check("ack", W'(ackValid), W'(1'b1));
        if (!w)
            check("rdData", rdData, view(stM));
        else begin
            check("ignored", W'(ignoredWrite), W'(d && |(m & conM)));
            // whole-register writes touch every policy bit
            check("breach", W'(policyBreach), W'(|(t & polM & (dat ^ rvM))));
            // indirect write loads reserved value into reserved stored bits
            model = d ? ((model & ~m) | (dat & m)) : ((dat & ~f) | (rvM & f));
        end
        @(negedge clk_sys);
        check("funcValue", funcValue, view(stM & ~f));
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        kd = $urandom(32'h1E7BA2D0);
        for (int i = 0; i < W; i++) begin
            kd = (i < 13) ? i : 0;
            stM[i] = kd == 0 || (kd >= 5 && kd <= 8);
            rvM[i] = kd != 0 && kd % 2 == 0;
            conM[i] = !stM[i];
            polM[i] = kd == 3 || kd == 4 || kd >= 9;
            resM[i] = kd == 5 || kd == 6;
            ctxM[i] = kd == 7 || kd == 8;
        end
        model = (RSTV & ~resM) | (rvM & resM);
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rdData in reset", rdData, '0);
        rst_n = 1'b1;
        op(1'b0, 1'b0, '0, '0, '0);
        $display("test reset readback done");
        op(1'b1, 1'b0, '0, '1, '0);
        op(1'b0, 1'b0, '0, '0, '1);
        op(1'b1, 1'b0, '0, '1, '1);
        op(1'b0, 1'b0, '0, '0, '0);
        $display("test indirect writes done");
        op(1'b1, 1'b1, '1, '0, '1);
        op(1'b1, 1'b1, '0, '1, '0);
        op(1'b1, 1'b1, '1, '1, '0);
        op(1'b0, 1'b0, '0, '0, '1);
        op(1'b1, 1'b1, '1, rvM, '0);
        op(1'b1, 1'b0, '0, rvM, '1);
        op(1'b0, 1'b0, '0, '0, '0);
        $display("test direct writes done");
        // mid-run reset must bring storage back to its reset contents
        @(negedge clk_sys);
        rst_n = 1'b0;
        model = (RSTV & ~resM) | (rvM & resM);
        repeat (2) @(negedge clk_sys);
        check("rdData in reset", rdData, '0);
        rst_n = 1'b1;
        op(1'b0, 1'b0, '0, '0, '1);
        $display("test mid-run reset done");
        repeat (300)
            op(1'($urandom), 1'($urandom), W'($urandom), W'($urandom), W'($urandom));
        $display("test random traffic done");
        tally_and_finish();
    end

    // hang guard
    initial begin
        #(100 * 60000);
        err_total++;
        tally_and_finish();
    end
endmodule // test_reserved_field_bank

bind reserved_field_bank reserved_field_monitor #(.WIDTH(WIDTH)) reserved_field_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqDirect(reqDirect), .reqMask(reqMask), .reqData(reqData), .ctxReserved(ctxReserved),
    .busy(busy), .ackValid(ackValid), .rdData(rdData), .funcValue(funcValue),
    .ignoredWrite(ignoredWrite), .policyBreach(policyBreach));
`default_nettype wire
